// *** dv/msi_link_chk.sv ***
`default_nettype none
module msi_link_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // message write
  input wire logic mwReq,
  input wire logic [63:0] mwAddr,
  input wire logic mwDac,
  input wire logic [31:0] mwData,
  input wire logic [3:0] mwBeN,
  input wire logic mwDone,
  input wire logic mwMasterAbort,
  input wire logic mwTargetAbort,
  input wire logic mwParityErr,
  // side-band pins
  input wire logic serrN,
  input wire logic intxN
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic bad;
  assign bad = mwDone && (mwMasterAbort || mwTargetAbort || mwParityErr);

  byte_enables_a: assert property (mwReq |-> mwBeN == msi_pkg::BE_ALL_N)
    else $error("byte enables not all on");
  upper_half_a: assert property (mwReq |-> mwData[31:16] == 16'h0000)
    else $error("upper data half not zero");
  addr_width_a: assert property (mwReq |-> mwDac == (mwAddr[63:32] != 32'h0))
    else $error("address width wrong");
  addr_align_a: assert property (mwReq |-> mwAddr[1:0] == 2'h0)
    else $error("address low bits set");
  req_hold_a: assert property (mwReq && !mwDone |=> mwReq && $stable(mwAddr) && $stable(mwData))
    else $error("write changed before done");
  req_drop_a: assert property (mwDone |=> !mwReq)
    else $error("write held after done");
  done_latency_a: assert property ($rose(mwReq) |=> mwDone)
    else $error("receiver slow to complete");
  legacy_quiet_a: assert property (mwReq |-> intxN)
    else $error("legacy pin with message");
  serr_cause_a: assert property ($fell(serrN) |-> $past(bad))
    else $error("error line without fault");
  serr_pulse_a: assert property (!serrN |=> serrN)
    else $error("error line too long");
  error_retry_a: assert property (bad |=> !mwReq ##[1:6] mwReq)
    else $error("failed write not retried");
endmodule : msi_link_chk
`default_nettype wire

// *** dv/msi_message_generator_tb_top.sv ***
`default_nettype none
module msi_message_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] swAddr = 8'h00;
  logic [31:0] swWdata = 32'h0;
  logic swWe = 1'b0;
  logic swRe = 1'b0;
  logic [31:0] swRdata;
  logic [msi_pkg::SRC_NUM-1:0] srcEvent = 4'h0;
  logic [msi_pkg::SRC_NUM-1:0] srcRearm = 4'h0;
  logic needAll = 1'b0;
  logic ordered = 1'b0;
  logic legacyReq = 1'b0;
  logic msgEnabled;
  logic [msi_pkg::SRC_NUM-1:0] srcPending;
  logic busy;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] v;

  always #5 clk = ~clk;

  msi_link_if u_msi_link_if (.clk(clk));
  msi_message_generator u_msi_message_generator (.link(u_msi_link_if.dev), .clk(clk),
    .rst(rst), .srcEvent(srcEvent), .srcRearm(srcRearm), .needAll(needAll),
    .ordered(ordered), .legacyReq(legacyReq), .msgEnabled(msgEnabled),
    .srcPending(srcPending), .busy(busy));
  msi_receiver u_msi_receiver (.link(u_msi_link_if.host), .clk(clk), .rst(rst),
    .swAddr(swAddr), .swWdata(swWdata), .swWe(swWe), .swRe(swRe), .swRdata(swRdata));
  msi_link_chk u_chk (.clk(clk), .rst(rst), .mwReq(u_msi_link_if.mwReq),
    .mwAddr(u_msi_link_if.mwAddr), .mwDac(u_msi_link_if.mwDac),
    .mwData(u_msi_link_if.mwData), .mwBeN(u_msi_link_if.mwBeN),
    .mwDone(u_msi_link_if.mwDone), .mwMasterAbort(u_msi_link_if.mwMasterAbort),
    .mwTargetAbort(u_msi_link_if.mwTargetAbort), .mwParityErr(u_msi_link_if.mwParityErr),
    .serrN(u_msi_link_if.serrN), .intxN(u_msi_link_if.intxN));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    swWe <= 1'b1;
    swAddr <= a;
    swWdata <= d;
    @(posedge clk);
    swWe <= 1'b0;
  endtask : sw_wr

  task sw_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    swRe <= 1'b1;
    swAddr <= a;
    @(posedge clk);
    swRe <= 1'b0;
    #1;
    d = swRdata;
  endtask : sw_rd

  task cfg_wr(input logic [4:0] o, input logic [31:0] d, input logic [3:0] be);
    sw_wr(msi_pkg::HOFS_CFG_ADDR, {27'h0, o});
    sw_wr(msi_pkg::HOFS_CFG_WDATA, d);
    sw_wr(msi_pkg::HOFS_CFG_CTRL, {24'h0, be, 4'h1});
    repeat (4) @(posedge clk);
  endtask : cfg_wr

  task cfg_rd(input logic [4:0] o, output logic [31:0] d);
    sw_wr(msi_pkg::HOFS_CFG_ADDR, {27'h0, o});
    sw_wr(msi_pkg::HOFS_CFG_CTRL, 32'h0000_00f2);
    repeat (4) @(posedge clk);
    sw_rd(msi_pkg::HOFS_CFG_RDATA, d);
  endtask : cfg_rd

  // pulse source events or rearms, then let the messages drain
  task fire(input logic [3:0] ev, input logic [3:0] re);
    @(posedge clk);
    srcEvent <= ev;
    srcRearm <= re;
    @(posedge clk);
    srcEvent <= 4'h0;
    srcRearm <= 4'h0;
    repeat (30) @(posedge clk);
  endtask : fire

  // compare the vectors seen by the receiver, then clear them
  task pend(input logic [31:0] exp);
    sw_rd(msi_pkg::HOFS_PENDING, v);
    check(v, exp);
    sw_wr(msi_pkg::HOFS_PENDING, 32'hffff_ffff);
  endtask : pend

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_header();
    cfg_rd(msi_pkg::OFS_HDR, v);
    check(v, 32'h0084_0005);
    check({31'h0, msgEnabled}, 32'h0);
    $display("header test done");
  endtask : t_header

  task t_setup();
    cfg_wr(msi_pkg::OFS_ADDR_LO, 32'hfee0_0013, 4'hf);
    cfg_rd(msi_pkg::OFS_ADDR_LO, v);
    check(v, 32'hfee0_0010);
    cfg_wr(msi_pkg::OFS_ADDR_HI, 32'h0, 4'hf);
    cfg_wr(msi_pkg::OFS_DATA, 32'h5a5a_1234, 4'hf);
    cfg_rd(msi_pkg::OFS_DATA, v);
    check(v, 32'h0000_1234);
    @(posedge clk);
    legacyReq <= 1'b1;
    repeat (3) @(posedge clk);
    sw_rd(msi_pkg::HOFS_FAULT, v);
    check(v & 32'h0000_0200, 32'h0000_0200);
    cfg_wr(msi_pkg::OFS_HDR, 32'h0021_0000, 4'h4);
    sw_rd(msi_pkg::HOFS_FAULT, v);
    check(v & 32'h0000_0200, 32'h0);
    check({31'h0, msgEnabled}, 32'h1);
    $display("setup test done");
  endtask : t_setup

  task t_vectors();
    @(posedge clk);
    needAll <= 1'b1;
    fire(4'hf, 4'h0);
    pend(32'h00f0_0000);
    check({28'h0, srcPending}, 32'h0);
    fire(4'h4, 4'h0);
    pend(32'h0);
    check({28'h0, srcPending}, 32'h4);
    fire(4'h0, 4'h4);
    pend(32'h0040_0000);
    fire(4'h0, 4'hf);
    $display("vector test done");
  endtask : t_vectors

  task t_faults();
    logic [31:0] m [3];
    m = '{32'h5000_0000, 32'h6000_0000, 32'hc100_0000};
    @(posedge clk);
    needAll <= 1'b0;
    cfg_wr(msi_pkg::OFS_CMDSTAT, 32'h0000_0100, 4'h3);
    for (int k = 0; k < 3; k++)
    begin
      sw_wr(msi_pkg::HOFS_FAULT, 32'h1 << k);
      fire(4'h2, 4'h0);
      pend(32'h0);
      check({28'h0, srcPending}, 32'h2);
      sw_rd(msi_pkg::HOFS_FAULT, v);
      check({31'h0, v[8]}, 32'h1);
      cfg_rd(msi_pkg::OFS_CMDSTAT, v);
      check(v & m[k], m[k]);
      sw_wr(msi_pkg::HOFS_FAULT, 32'h0000_0100);
      repeat (20) @(posedge clk);
      pend(32'h0020_0000);
      cfg_wr(msi_pkg::OFS_CMDSTAT, 32'hffff_0100, 4'hf);
    end
    $display("fault test done");
  endtask : t_faults

  task t_order();
    @(posedge clk);
    ordered <= 1'b1;
    fire(4'h3, 4'h0);
    pend(32'h0010_0000);
    fire(4'h0, 4'h1);
    pend(32'h0020_0000);
    fire(4'h0, 4'hf);
    @(posedge clk);
    ordered <= 1'b0;
    $display("order test done");
  endtask : t_order

  task t_fold();
    cfg_wr(msi_pkg::OFS_HDR, 32'h0071_0000, 4'h4);
    cfg_rd(msi_pkg::OFS_HDR, v);
    check(v, 32'h00a5_0005);
    cfg_wr(msi_pkg::OFS_HDR, 32'h0001_0000, 4'h4);
    cfg_wr(msi_pkg::OFS_ADDR_HI, 32'h0000_0001, 4'hf);
    @(posedge clk);
    srcEvent <= 4'ha;
    @(posedge clk);
    srcEvent <= 4'h0;
    // the write stands from this edge until the edge after completion
    @(posedge clk);
    #1;
    check({31'h0, busy}, 32'h1);
    check(u_msi_link_if.mwAddr[63:32], 32'h0000_0001);
    check(u_msi_link_if.mwAddr[31:0], 32'hfee0_0010);
    check({31'h0, u_msi_link_if.mwDac}, 32'h1);
    check(u_msi_link_if.mwData, 32'h0000_1234);
    repeat (30) @(posedge clk);
    pend(32'h0010_0000);
    check({28'h0, srcPending}, 32'h0);
    check({31'h0, busy}, 32'h0);
    $display("fold test done");
  endtask : t_fold

  // ----------------------------------------
  // run control
  // ----------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_header();
    t_setup();
    t_vectors();
    t_faults();
    t_order();
    t_fold();
    print_verdict();
  end
endmodule : msi_message_generator_tb_top
`default_nettype wire

// *** rtl/msi_link_if.sv ***
`default_nettype none
interface msi_link_if (
  input wire logic clk
);
  // configuration access
  logic [4:0] cfgAddr;
  logic [31:0] cfgWdata;
  logic [3:0] cfgBe;
  logic cfgWe;
  logic cfgRe;
  logic [31:0] cfgRdata;
  // message write
  logic mwReq;
  logic [63:0] mwAddr;
  logic mwDac;
  logic [31:0] mwData;
  logic [3:0] mwBeN;
  logic mwDone;
  logic mwMasterAbort;
  logic mwTargetAbort;
  logic mwParityErr;
  // side-band pins, active low
  logic serrN;
  logic intxN;

  modport dev (
    input cfgAddr, cfgWdata, cfgBe, cfgWe, cfgRe,
    output cfgRdata,
    output mwReq, mwAddr, mwDac, mwData, mwBeN,
    input mwDone, mwMasterAbort, mwTargetAbort, mwParityErr,
    output serrN, intxN
  );
  modport host (
    output cfgAddr, cfgWdata, cfgBe, cfgWe, cfgRe,
    input cfgRdata,
    input mwReq, mwAddr, mwDac, mwData, mwBeN,
    output mwDone, mwMasterAbort, mwTargetAbort, mwParityErr,
    input serrN, intxN
  );
endinterface : msi_link_if
`default_nettype wire

// *** rtl/msi_message_generator.sv ***
// Local design decisions: the address-and-strobe port and the register addresses.
`default_nettype none
module msi_message_generator (
  // link to the bus side
  msi_link_if.dev link,
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // interrupt sources
  input wire logic [msi_pkg::SRC_NUM-1:0] srcEvent,
  input wire logic [msi_pkg::SRC_NUM-1:0] srcRearm,
  input wire logic needAll,
  input wire logic ordered,
  input wire logic legacyReq,
  // status
  output logic msgEnabled,
  output logic [msi_pkg::SRC_NUM-1:0] srcPending,
  output logic busy
);

  // ------------------------------------------------------------
  // types and helpers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } state_t;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // granted count never exceeds the request; both stay powers of two
  function automatic logic [2:0] gntClamp(input logic [2:0] gnt);
    return (gnt > msi_pkg::REQ_CODE) ? msi_pkg::REQ_CODE : gnt;
  endfunction : gntClamp

  function automatic logic [msi_pkg::VEC_BITS-1:0] vecMask(input logic [2:0] gnt);
    logic [2:0] g;
    logic [msi_pkg::VEC_BITS-1:0] m;
    g = gntClamp(gnt);
    m = '0;
    for (int k = 0; k < msi_pkg::VEC_BITS; k++)
    begin
      if (k < int'(g))
      begin
        m[k] = 1'b1;
      end
    end
    return m;
  endfunction : vecMask

  // ------------------------------------------------------------
  // configuration state
  // ------------------------------------------------------------
  logic enR;
  logic [2:0] gntR;
  logic [31:0] addrLoR;
  logic [31:0] addrHiR;
  logic [15:0] dataR;
  logic [15:0] cmdR;
  logic [15:0] statR;
  logic [31:0] rdataR;
  logic [15:0] ctlWord;
  logic [31:0] loMerge;
  logic [31:0] dataMerge;
  logic [31:0] cmdMerge;
  logic [msi_pkg::VEC_BITS-1:0] mask;

  assign ctlWord = {8'h00, msi_pkg::WIDE_SUPPORT, gntR, msi_pkg::REQ_CODE, enR};
  assign mask = vecMask(gntR);
  assign loMerge = mergeBytes(addrLoR, link.cfgWdata, link.cfgBe);
  assign dataMerge = mergeBytes({16'h0000, dataR}, link.cfgWdata, link.cfgBe);
  assign cmdMerge = mergeBytes({16'h0000, cmdR}, link.cfgWdata, link.cfgBe);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      enR <= msi_pkg::RST_EN;
      gntR <= msi_pkg::RST_GNT;
    end
    else if (link.cfgWe && link.cfgAddr == msi_pkg::OFS_HDR && link.cfgBe[2])
    begin
      enR <= link.cfgWdata[msi_pkg::CTL_BASE + msi_pkg::CTL_EN_POS];
      gntR <= gntClamp(link.cfgWdata[msi_pkg::CTL_BASE + msi_pkg::CTL_GNT_LSB +: 3]);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addrLoR <= '0;
      addrHiR <= '0;
      dataR <= '0;
      cmdR <= msi_pkg::RST_CMD;
    end
    else if (link.cfgWe)
    begin
      case (link.cfgAddr)
        msi_pkg::OFS_ADDR_LO: addrLoR <= {loMerge[31:2], 2'b00};
        msi_pkg::OFS_ADDR_HI: addrHiR <= mergeBytes(addrHiR, link.cfgWdata, link.cfgBe);
        msi_pkg::OFS_DATA: dataR <= dataMerge[15:0];
        msi_pkg::OFS_CMDSTAT: cmdR <= cmdMerge[15:0];
        default: cmdR <= cmdR;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdataR <= '0;
    end
    else if (link.cfgRe)
    begin
      case (link.cfgAddr)
        msi_pkg::OFS_HDR: rdataR <= {ctlWord, msi_pkg::CAP_NEXT, msi_pkg::CAP_ID};
        msi_pkg::OFS_ADDR_LO: rdataR <= addrLoR;
        msi_pkg::OFS_ADDR_HI: rdataR <= addrHiR;
        msi_pkg::OFS_DATA: rdataR <= {16'h0000, dataR};
        msi_pkg::OFS_CMDSTAT: rdataR <= {statR, cmdR};
        default: rdataR <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // sources: pending and rearm locks
  // ------------------------------------------------------------
  state_t stateR;
  logic [msi_pkg::SRC_NUM-1:0] pendR;
  logic [msi_pkg::SRC_NUM-1:0] lockR;
  logic [msi_pkg::SRC_NUM-1:0] eligible;
  logic [msi_pkg::VEC_BITS-1:0] curVecR;
  logic doneOk;
  logic doneBad;
  logic [msi_pkg::SRC_NUM-1:0] hitVec;
  logic [msi_pkg::VEC_BITS-1:0] pickVec;
  logic pickAny;

  assign doneOk = stateR == ST_WAIT && link.mwDone && !link.mwMasterAbort
                  && !link.mwTargetAbort && !link.mwParityErr;
  assign doneBad = stateR == ST_WAIT && link.mwDone && !doneOk;

  always_comb
  begin
    pickVec = '0;
    pickAny = 1'b0;
    for (int i = 0; i < msi_pkg::SRC_NUM; i++)
    begin
      // sources beyond the grant share a vector
      hitVec[i] = (msi_pkg::VEC_BITS'(i) & mask) == curVecR;
      eligible[i] = pendR[i] && enR && !(needAll && lockR[i])
                    && !(ordered && |lockR);
    end
    for (int i = msi_pkg::SRC_NUM - 1; i >= 0; i--)
    begin
      if (eligible[i])
      begin
        pickVec = msi_pkg::VEC_BITS'(i) & mask;
        pickAny = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pendR <= '0;
      lockR <= '0;
    end
    else
    begin
      for (int i = 0; i < msi_pkg::SRC_NUM; i++)
      begin
        // a new event wins over a completing write
        if (srcEvent[i])
        begin
          pendR[i] <= 1'b1;
        end
        else if (doneOk && hitVec[i])
        begin
          pendR[i] <= 1'b0;
        end
        if (doneOk && hitVec[i] && (needAll || ordered))
        begin
          lockR[i] <= 1'b1;
        end
        else if (srcRearm[i])
        begin
          lockR[i] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // message write sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stateR <= ST_IDLE;
      curVecR <= '0;
      link.mwReq <= 1'b0;
      link.mwAddr <= '0;
      link.mwDac <= 1'b0;
      link.mwData <= '0;
      link.mwBeN <= msi_pkg::BE_ALL_N;
    end
    else
    begin
      case (stateR)
        ST_IDLE:
        begin
          if (pickAny)
          begin
            stateR <= ST_WAIT;
            curVecR <= pickVec;
            link.mwReq <= 1'b1;
            link.mwAddr <= {addrHiR, addrLoR};
            link.mwDac <= addrHiR != 32'h00000000;
            link.mwData <= {16'h0000, dataR[15:msi_pkg::VEC_BITS],
                            (dataR[msi_pkg::VEC_BITS-1:0] & ~mask) | (pickVec & mask)};
            link.mwBeN <= msi_pkg::BE_ALL_N;
          end
        end
        ST_WAIT:
        begin
          if (link.mwDone)
          begin
            stateR <= ST_IDLE;
            link.mwReq <= 1'b0;
          end
        end
        default:
        begin
          stateR <= ST_IDLE;
          link.mwReq <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // error reporting and side-band pins
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      statR <= msi_pkg::RST_STAT;
      link.serrN <= 1'b1;
    end
    else
    begin
      link.serrN <= !(doneBad && cmdR[msi_pkg::CMD_SERR_EN_POS]);
      for (int k = 0; k < 16; k++)
      begin
        // set wins over a write-one clear
        if (link.cfgWe && link.cfgAddr == msi_pkg::OFS_CMDSTAT && link.cfgBe[2 + k/8]
            && link.cfgWdata[16 + k])
        begin
          statR[k] <= 1'b0;
        end
      end
      if (doneBad && link.mwMasterAbort)
      begin
        statR[msi_pkg::STAT_RMA_POS] <= 1'b1;
      end
      if (doneBad && link.mwTargetAbort)
      begin
        statR[msi_pkg::STAT_RTA_POS] <= 1'b1;
      end
      if (doneBad && link.mwParityErr)
      begin
        statR[msi_pkg::STAT_MDPE_POS] <= 1'b1;
        statR[msi_pkg::STAT_DPE_POS] <= 1'b1;
      end
      if (doneBad && cmdR[msi_pkg::CMD_SERR_EN_POS])
      begin
        statR[msi_pkg::STAT_SSE_POS] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.intxN <= 1'b1;
      msgEnabled <= 1'b0;
    end
    else
    begin
      link.intxN <= !(legacyReq && !enR);
      msgEnabled <= enR;
    end
  end

  assign link.cfgRdata = rdataR;
  assign srcPending = pendR;
  assign busy = stateR[1];

endmodule : msi_message_generator
`default_nettype wire

// *** rtl/msi_pkg.sv ***
`default_nettype none
package msi_pkg;
  // ------------------------------------------------------------
  // capability identification and control word layout
  // ------------------------------------------------------------
  localparam logic [7:0] CAP_ID = 8'h05;
  localparam logic [7:0] CAP_NEXT = 8'h00;
  localparam int CTL_BASE = 16;
  localparam int CTL_EN_POS = 0;
  localparam int CTL_REQ_LSB = 1;
  localparam int CTL_GNT_LSB = 4;
  localparam int CTL_WIDE_POS = 7;
  localparam logic [2:0] REQ_CODE = 3'h2;
  localparam logic WIDE_SUPPORT = 1'b1;
  localparam logic RST_EN = 1'b0;
  localparam logic [2:0] RST_GNT = 3'h0;
  localparam int SRC_NUM = 4;
  localparam int VEC_BITS = 5;

  // ------------------------------------------------------------
  // device configuration offsets
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_HDR = 5'h00;
  localparam logic [4:0] OFS_ADDR_LO = 5'h04;
  localparam logic [4:0] OFS_ADDR_HI = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0c;
  localparam logic [4:0] OFS_CMDSTAT = 5'h10;

  // ------------------------------------------------------------
  // command and status fields (status sits at bits 31:16)
  // ------------------------------------------------------------
  localparam int CMD_SERR_EN_POS = 8;
  localparam int STAT_MDPE_POS = 8;
  localparam int STAT_RTA_POS = 12;
  localparam int STAT_RMA_POS = 13;
  localparam int STAT_SSE_POS = 14;
  localparam int STAT_DPE_POS = 15;
  localparam logic [15:0] RST_CMD = 16'h0000;
  localparam logic [15:0] RST_STAT = 16'h0000;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [3:0] BE_DATA_WORD = 4'h3;

  // ------------------------------------------------------------
  // receiver software registers
  // ------------------------------------------------------------
  localparam logic [7:0] HOFS_CFG_ADDR = 8'h00;
  localparam logic [7:0] HOFS_CFG_WDATA = 8'h04;
  localparam logic [7:0] HOFS_CFG_CTRL = 8'h08;
  localparam logic [7:0] HOFS_CFG_RDATA = 8'h0c;
  localparam logic [7:0] HOFS_PENDING = 8'h10;
  localparam logic [7:0] HOFS_FAULT = 8'h14;
  localparam int HCTL_WGO_POS = 0;
  localparam int HCTL_RGO_POS = 1;
  localparam int HCTL_BE_LSB = 4;
  localparam int HFLT_TA_POS = 0;
  localparam int HFLT_MA_POS = 1;
  localparam int HFLT_PE_POS = 2;
  localparam int HFLT_SERR_POS = 8;
  localparam int HFLT_INTX_POS = 9;
  localparam logic [3:0] RST_HBE = 4'hf;
endpackage : msi_pkg
`default_nettype wire

// *** rtl/msi_receiver.sv ***
`default_nettype none
module msi_receiver (
  // link to the message source
  msi_link_if.host link,
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software port
  input wire logic [7:0] swAddr,
  input wire logic [31:0] swWdata,
  input wire logic swWe,
  input wire logic swRe,
  output logic [31:0] swRdata
);

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  logic [4:0] cfgAddrR;
  logic [31:0] cfgWdataR;
  logic [3:0] cfgBeR;
  logic [31:0] cfgRdataR;
  logic [31:0] pendR;
  logic [2:0] faultR;
  logic serrSeenR;
  logic rdPendR;
  logic busyR;
  logic take;
  logic ctlWr;

  assign ctlWr = swWe && swAddr == msi_pkg::HOFS_CFG_CTRL;
  assign take = link.mwReq && !busyR && !link.mwDone;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfgAddrR <= '0;
      cfgWdataR <= '0;
      cfgBeR <= msi_pkg::RST_HBE;
      faultR <= '0;
    end
    else if (swWe)
    begin
      case (swAddr)
        msi_pkg::HOFS_CFG_ADDR: cfgAddrR <= swWdata[4:0];
        msi_pkg::HOFS_CFG_WDATA: cfgWdataR <= swWdata;
        msi_pkg::HOFS_CFG_CTRL: cfgBeR <= swWdata[msi_pkg::HCTL_BE_LSB +: 4];
        msi_pkg::HOFS_FAULT: faultR <= swWdata[2:0];
        default: faultR <= faultR;
      endcase
    end
  end

  // ------------------------------------------------------------
  // configuration access issue
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.cfgWe <= 1'b0;
      link.cfgRe <= 1'b0;
      link.cfgAddr <= '0;
      link.cfgWdata <= '0;
      link.cfgBe <= '0;
      rdPendR <= 1'b0;
      cfgRdataR <= '0;
    end
    else
    begin
      link.cfgWe <= ctlWr && swWdata[msi_pkg::HCTL_WGO_POS];
      link.cfgRe <= ctlWr && !swWdata[msi_pkg::HCTL_WGO_POS] && swWdata[msi_pkg::HCTL_RGO_POS];
      link.cfgAddr <= cfgAddrR;
      link.cfgWdata <= cfgWdataR;
      // message data is only ever written as its two low bytes
      link.cfgBe <= (cfgAddrR == msi_pkg::OFS_DATA) ? (swWdata[msi_pkg::HCTL_BE_LSB +: 4]
                    & msi_pkg::BE_DATA_WORD) : swWdata[msi_pkg::HCTL_BE_LSB +: 4];
      rdPendR <= link.cfgRe;
      if (rdPendR)
      begin
        cfgRdataR <= link.cfgRdata;
      end
    end
  end

  // ------------------------------------------------------------
  // message completion: latch, then finish at once
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.mwDone <= 1'b0;
      link.mwTargetAbort <= 1'b0;
      link.mwMasterAbort <= 1'b0;
      link.mwParityErr <= 1'b0;
      busyR <= 1'b0;
    end
    else
    begin
      link.mwDone <= take;
      link.mwTargetAbort <= take && faultR[msi_pkg::HFLT_TA_POS];
      link.mwMasterAbort <= take && faultR[msi_pkg::HFLT_MA_POS];
      link.mwParityErr <= take && faultR[msi_pkg::HFLT_PE_POS];
      if (take)
      begin
        busyR <= 1'b1;
      end
      else if (!link.mwReq)
      begin
        busyR <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pendR <= '0;
      serrSeenR <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < 32; k++)
      begin
        // a message arriving wins over a clear
        if (take && faultR == 3'h0 && link.mwData[msi_pkg::VEC_BITS-1:0] == k[4:0])
        begin
          pendR[k] <= 1'b1;
        end
        else if (swWe && swAddr == msi_pkg::HOFS_PENDING && swWdata[k])
        begin
          pendR[k] <= 1'b0;
        end
      end
      if (!link.serrN)
      begin
        serrSeenR <= 1'b1;
      end
      else if (swWe && swAddr == msi_pkg::HOFS_FAULT && swWdata[msi_pkg::HFLT_SERR_POS])
      begin
        serrSeenR <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      swRdata <= '0;
    end
    else if (swRe)
    begin
      case (swAddr)
        msi_pkg::HOFS_CFG_ADDR: swRdata <= {27'h0000000, cfgAddrR};
        msi_pkg::HOFS_CFG_WDATA: swRdata <= cfgWdataR;
        msi_pkg::HOFS_CFG_CTRL: swRdata <= {24'h000000, cfgBeR, 4'h0};
        msi_pkg::HOFS_CFG_RDATA: swRdata <= cfgRdataR;
        msi_pkg::HOFS_PENDING: swRdata <= pendR;
        msi_pkg::HOFS_FAULT: swRdata <= {22'h000000, !link.intxN, serrSeenR, 5'h00, faultR};
        default: swRdata <= '0;
      endcase
    end
    else
    begin
      swRdata <= '0;
    end
  end

endmodule : msi_receiver
`default_nettype wire
